// *** design/cidfo_pkg.sv ***
// constants and types shared by the caller id fsk output interface
package cidfo_pkg;
	localparam int CLK_HZ        = 40_000_000;
	localparam int CLK_MHZ       = 40;
	localparam int BAUD          = 1200;
	localparam int BIT_CYC       = CLK_HZ / BAUD;
	localparam int HALF_BIT_CYC  = CLK_HZ / (2 * BAUD);
	localparam int CD_HOLD_MS    = 8;
	localparam int CD_HOLD_CYC   = CD_HOLD_MS * (CLK_HZ / 1000);
	localparam int SETTLE_US     = 10;
	localparam int SETTLE_CYC    = SETTLE_US * CLK_MHZ;
	localparam int CLK_LOW_NS    = 2000;
	localparam int CLK_LOW_CYC   = (CLK_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int RDY_PULSE_NS  = 100000;
	localparam int RDY_PULSE_CYC = (RDY_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int RING_DELAY_MS = 100;
	localparam int RING_DELAY_CYC = RING_DELAY_MS * (CLK_HZ / 1000);
	localparam int PRESENT_MS    = 40;
	localparam int PRESENT_CYC   = PRESENT_MS * (CLK_HZ / 1000);
	localparam int ABSENT_MS     = 30;
	localparam int ABSENT_CYC    = ABSENT_MS * (CLK_HZ / 1000);
	localparam int BYTE_BITS     = 8;

	// register byte offsets
	localparam logic [7:0] RING_DELAY_OFS = 8'h00;
	localparam logic [7:0] PRESENT_OFS    = 8'h04;
	localparam logic [7:0] ABSENT_OFS     = 8'h08;
	localparam logic [7:0] STATUS_OFS     = 8'h0c;

	// status field positions
	localparam int ST_CD_BIT    = 0;
	localparam int ST_ALERT_BIT = 1;
	localparam int ST_RING_BIT  = 2;
	localparam int ST_MODE_BIT  = 3;
	localparam int ST_BYTE_LSB  = 8;

	// positions in the synchronised pin vector
	localparam int IX_MODE  = 0;
	localparam int IX_FSK_ENABLE  = 1;
	localparam int IX_SLEEP = 2;
	localparam int IX_BIT   = 3;
	localparam int IX_AMP   = 4;
	localparam int IX_TONEH = 5;
	localparam int IX_TONEL = 6;
	localparam int IX_RING  = 7;
	localparam int IX_DATA_CLOCK  = 8;
	localparam int N_PINS   = 9;

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} cidfo_rx_t;
endpackage : cidfo_pkg

// *** design/cidfo_top.sv ***
// caller id fsk serial output interface with alert, ring and interrupt logic
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/100ps

// What this block does
// - demodulator output used only while fsk_enable high and settled
// - carrier_detect_n falls after 8 ms of continuous sufficient amplitude
// - carrier_detect_n rises after more than 8 ms of insufficient amplitude
// - carrier inactive in mode 0: clock, data and byte_ready_n held high
// - carrier inactive in mode 1: shift register frozen, byte_ready_n high
// - mode low drives data_clock out; mode high takes data_clock as input
// - mode 0 emits exactly eight clock pulses per received character
// - mode 0 clock falls at data bit centres, none for start or stop
// - mode 0 pulses byte_ready_n low once after the eight data bits
// - mode 1 byte_ready_n falls on new byte, rises on first clock rise
// - mode 1 byte_ready_n ends after half a bit time without clock
// - mode 1 byte shifted out lsb first, one bit per rising edge
// - mode 1 extra clock edges after the msb are ignored
// - data line carries 1 for mark and 0 for space
// - irq_n pulled low while ring, byte ready or alert is active
// - sleep forces alert_qualified low and clears its guard timing
// - sleep disables everything but ring detection and the apb registers
// - alert_raw high while both alert tones present and awake
// - alert_qualified follows alert_raw through present and absent guards
// - ring_detect_n low while sensing ring and for a delay after
// - sleep high also clears carrier detect and enable settling
// - all timing derived from the system clock
module cidfo_top #(
	parameter logic [23:0] BIT_CYC   = 24'(cidfo_pkg::BIT_CYC),
	parameter logic [23:0] HALF_CYC  = 24'(cidfo_pkg::HALF_BIT_CYC),
	parameter logic [23:0] CD_CYC    = 24'(cidfo_pkg::CD_HOLD_CYC),
	parameter logic [23:0] RING_RST  = 24'(cidfo_pkg::RING_DELAY_CYC),
	parameter logic [23:0] PRES_RST  = 24'(cidfo_pkg::PRESENT_CYC),
	parameter logic [23:0] ABS_RST   = 24'(cidfo_pkg::ABSENT_CYC)
) (
	// clock and reset
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RESET_N,
	// apb slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// control pins and demodulator results
	input  wire logic        I_MODE,
	input  wire logic        I_FSK_ENABLE,
	input  wire logic        I_SLEEP,
	input  wire logic        I_FSK_BIT,
	input  wire logic        I_AMP_OK,
	input  wire logic        I_TONE_HIGH,
	input  wire logic        I_TONE_LOW,
	input  wire logic        I_RING_SENSE_IN,
	// three wire serial port
	input  wire logic        I_DATA_CLOCK,
	output logic             O_DATA_CLOCK,
	output logic             O_DATA_CLOCK_OE,
	output logic             O_DATA,
	output logic             O_BYTE_READY_N,
	output logic             O_CARRIER_DETECT_N,
	// alert, ring and interrupt
	output logic             O_ALERT_RAW,
	output logic             O_ALERT_QUALIFIED,
	output logic             O_RING_DETECT_N,
	output logic             O_IRQ_N,
	output logic             O_IRQ_N_OE
);
	localparam logic [23:0] BIT_LD    = BIT_CYC - 24'h000001;
	localparam logic [23:0] HALF_LD   = HALF_CYC - 24'h000001;
	localparam logic [23:0] SETTLE    = 24'(cidfo_pkg::SETTLE_CYC);
	localparam logic [23:0] CLK_LOW   = 24'(cidfo_pkg::CLK_LOW_CYC);
	localparam logic [23:0] RDY_LD    = 24'(cidfo_pkg::RDY_PULSE_CYC) - 24'h000001;
	localparam logic [3:0]  NBITS     = 4'(cidfo_pkg::BYTE_BITS);
	localparam logic [2:0]  LAST_BIT  = 3'(cidfo_pkg::BYTE_BITS - 1);
	localparam cidfo_pkg::cidfo_rx_t RX_IDLE_A  = cidfo_pkg::RX_IDLE;
	localparam cidfo_pkg::cidfo_rx_t RX_START_A = cidfo_pkg::RX_START;
	localparam cidfo_pkg::cidfo_rx_t RX_DATA_A  = cidfo_pkg::RX_DATA;
	localparam cidfo_pkg::cidfo_rx_t RX_STOP_A  = cidfo_pkg::RX_STOP;

	logic                         rst_meta_reg;
	logic                         rst_sync_reg;
	logic                         rst_n;
	logic [cidfo_pkg::N_PINS-1:0] pin_meta_reg;
	logic [cidfo_pkg::N_PINS-1:0] pin_sync_reg;
	logic                         mode;
	logic                         sleep;
	logic                         data_clock_prev_reg;
	logic                         data_clock_rise;
	logic [23:0]                  settle_cnt_reg;
	logic                         demod_ok;
	logic                         cd_on_reg;
	logic [23:0]                  cd_cnt_reg;
	logic                         gate;
	cidfo_pkg::cidfo_rx_t         rx_state_reg;
	logic [23:0]                  rx_tmr_reg;
	logic [2:0]                   bit_cnt_reg;
	logic [7:0]                   rx_byte_reg;
	logic [7:0]                   last_byte_reg;
	logic                         bit_sample;
	logic                         byte_done;
	logic                         m0_clk_reg;
	logic                         m0_data_reg;
	logic [23:0]                  lo_cnt_reg;
	logic                         rdy_n_reg;
	logic [23:0]                  rdy_cnt_reg;
	logic [7:0]                   shift_reg;
	logic [3:0]                   left_reg;
	logic                         m1_data_reg;
	logic                         alert_raw_reg;
	logic                         alert_q_reg;
	logic [23:0]                  al_cnt_reg;
	logic [23:0]                  al_limit;
	logic                         ring_on_reg;
	logic [23:0]                  ring_cnt_reg;
	logic [23:0]                  ring_delay_reg;
	logic [23:0]                  present_reg;
	logic [23:0]                  absent_reg;
	logic [31:0]                  prdata_reg;
	logic                         addr_ok;
	logic [3:0]                   edge_cnt_reg;
	logic [23:0]                  rdy_low_reg;

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!rst_n);

	// reset released through two flops
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// every control and serial pin crosses two flops before use; the apb inputs are used directly
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_reg  <= '0;
			pin_sync_reg  <= '0;
			data_clock_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg  <= {I_DATA_CLOCK, I_RING_SENSE_IN, I_TONE_LOW, I_TONE_HIGH, I_AMP_OK,
				I_FSK_BIT, I_SLEEP, I_FSK_ENABLE, I_MODE};
			pin_sync_reg  <= pin_meta_reg;
			data_clock_prev_reg <= pin_sync_reg[cidfo_pkg::IX_DATA_CLOCK];
		end
	end
	assign mode      = pin_sync_reg[cidfo_pkg::IX_MODE];
	assign sleep     = pin_sync_reg[cidfo_pkg::IX_SLEEP];
	assign data_clock_rise = pin_sync_reg[cidfo_pkg::IX_DATA_CLOCK] & ~data_clock_prev_reg;

	// enable settling, restarted on every rise of fsk_enable
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			settle_cnt_reg <= '0;
		end else if (sleep || !pin_sync_reg[cidfo_pkg::IX_FSK_ENABLE]) begin
			settle_cnt_reg <= '0;
		end else if (settle_cnt_reg != SETTLE) begin
			settle_cnt_reg <= settle_cnt_reg + 24'h000001;
		end
	end
	assign demod_ok = (settle_cnt_reg == SETTLE);

	// carrier detect: one counter measures how long the input disagrees with the output
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cd_on_reg  <= 1'b0;
			cd_cnt_reg <= '0;
		end else if (sleep) begin
			cd_on_reg  <= 1'b0;
			cd_cnt_reg <= '0;
		end else if ((pin_sync_reg[cidfo_pkg::IX_AMP] & demod_ok) == cd_on_reg) begin
			cd_cnt_reg <= '0;
		end else if (cd_cnt_reg == (cd_on_reg ? CD_CYC : CD_CYC - 24'h000001)) begin
			cd_on_reg  <= ~cd_on_reg;
			cd_cnt_reg <= '0;
		end else begin
			cd_cnt_reg <= cd_cnt_reg + 24'h000001;
		end
	end
	assign gate = cd_on_reg & demod_ok & ~sleep;

	property p_cd_hold;
		$fell(O_CARRIER_DETECT_N) |-> $past(cd_cnt_reg) == CD_CYC - 24'h000001;
	endproperty
	a_cd_hold: assert property (p_cd_hold)
		else $error("carrier detect fell before the hold time");
	property p_cd_rel;
		$rose(O_CARRIER_DETECT_N) && !$past(sleep) |-> $past(cd_cnt_reg) == CD_CYC;
	endproperty
	a_cd_rel: assert property (p_cd_rel)
		else $error("carrier detect released too early");

	// character receiver, sampling at bit centres
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_reg <= RX_IDLE_A;
			rx_tmr_reg   <= '0;
			bit_cnt_reg  <= '0;
			rx_byte_reg  <= '0;
		end else if (!gate) begin
			rx_state_reg <= RX_IDLE_A;
			rx_tmr_reg   <= '0;
			bit_cnt_reg  <= '0;
		end else begin
			case (rx_state_reg)
				RX_IDLE_A: begin
					if (!pin_sync_reg[cidfo_pkg::IX_BIT]) begin
						rx_state_reg <= RX_START_A;
						rx_tmr_reg   <= HALF_LD;
					end
				end
				RX_START_A: begin
					if (rx_tmr_reg != '0) begin
						rx_tmr_reg <= rx_tmr_reg - 24'h000001;
					end else if (!pin_sync_reg[cidfo_pkg::IX_BIT]) begin
						rx_state_reg <= RX_DATA_A;
						rx_tmr_reg   <= BIT_LD;
						bit_cnt_reg  <= '0;
					end else begin
						rx_state_reg <= RX_IDLE_A;
					end
				end
				RX_DATA_A: begin
					if (rx_tmr_reg != '0) begin
						rx_tmr_reg <= rx_tmr_reg - 24'h000001;
					end else begin
						rx_byte_reg <= {pin_sync_reg[cidfo_pkg::IX_BIT], rx_byte_reg[7:1]};
						rx_tmr_reg  <= BIT_LD;
						if (bit_cnt_reg == LAST_BIT) begin
							rx_state_reg <= RX_STOP_A;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 3'h1;
						end
					end
				end
				RX_STOP_A: begin
					if (rx_tmr_reg != '0) begin
						rx_tmr_reg <= rx_tmr_reg - 24'h000001;
					end else begin
						rx_state_reg <= RX_IDLE_A;
					end
				end
				default: begin
					rx_state_reg <= RX_IDLE_A;
				end
			endcase
		end
	end
	assign bit_sample = gate && rx_state_reg == RX_DATA_A && rx_tmr_reg == '0;
	// a framing error (space at the stop centre) drops the character silently
	assign byte_done  = gate && rx_state_reg == RX_STOP_A && rx_tmr_reg == '0 &&
		pin_sync_reg[cidfo_pkg::IX_BIT];

	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			last_byte_reg <= '0;
		end else if (byte_done) begin
			last_byte_reg <= rx_byte_reg;
		end
	end

	// mode 0 clock: low at the sample, rising a fixed short time later
	// the low time must stay below one bit time, or the pulses of a burst merge
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			m0_clk_reg  <= 1'b1;
			m0_data_reg <= 1'b1;
			lo_cnt_reg  <= '0;
		end else if (!gate || mode) begin
			m0_clk_reg  <= 1'b1;
			m0_data_reg <= 1'b1;
			lo_cnt_reg  <= '0;
		end else if (bit_sample) begin
			m0_clk_reg  <= 1'b0;
			m0_data_reg <= pin_sync_reg[cidfo_pkg::IX_BIT];
			lo_cnt_reg  <= CLK_LOW;
		end else if (lo_cnt_reg != '0) begin
			lo_cnt_reg <= lo_cnt_reg - 24'h000001;
			if (lo_cnt_reg == 24'h000001) begin
				m0_clk_reg <= 1'b1;
			end
		end
	end

	// byte ready for both modes
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rdy_n_reg   <= 1'b1;
			rdy_cnt_reg <= '0;
		end else if (!gate) begin
			rdy_n_reg   <= 1'b1;
			rdy_cnt_reg <= '0;
		end else if (byte_done) begin
			rdy_n_reg   <= 1'b0;
			rdy_cnt_reg <= mode ? HALF_LD : RDY_LD;
		end else if (!rdy_n_reg) begin
			if ((mode && data_clock_rise) || rdy_cnt_reg == '0) begin
				rdy_n_reg <= 1'b1;
			end else begin
				rdy_cnt_reg <= rdy_cnt_reg - 24'h000001;
			end
		end
	end

	// mode 1 shift register, clocked by the partner's rising edges
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg   <= '0;
			left_reg    <= '0;
			m1_data_reg <= 1'b1;
		end else if (!gate) begin
			left_reg <= '0;
		end else if (mode && byte_done) begin
			shift_reg <= rx_byte_reg;
			left_reg  <= NBITS;
		end else if (mode && data_clock_rise && left_reg != '0) begin
			m1_data_reg <= shift_reg[0];
			shift_reg   <= {1'b0, shift_reg[7:1]};
			left_reg    <= left_reg - 4'h1;
		end
	end

	assign O_DATA_CLOCK       = m0_clk_reg;
	assign O_DATA_CLOCK_OE    = ~mode;
	assign O_DATA             = mode ? m1_data_reg : m0_data_reg;
	assign O_BYTE_READY_N     = rdy_n_reg;
	assign O_CARRIER_DETECT_N = ~cd_on_reg;

	// helper counters for the checks below
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			edge_cnt_reg <= '0;
			rdy_low_reg  <= '0;
		end else begin
			if (rx_state_reg == RX_IDLE_A) begin
				edge_cnt_reg <= '0;
			end else if (!mode && !m0_clk_reg && lo_cnt_reg == 24'h000001) begin
				edge_cnt_reg <= edge_cnt_reg + 4'h1;
			end
			rdy_low_reg <= (!rdy_n_reg && mode) ? rdy_low_reg + 24'h000001 : '0;
		end
	end

	// a mode change swaps the data mux, so the idle checks need the mode to stay put
	property p_m0_idle;
		!mode && !gate ##1 !mode |-> O_DATA_CLOCK && O_DATA && O_BYTE_READY_N;
	endproperty
	a_m0_idle: assert property (p_m0_idle)
		else $error("mode 0 lines not idle without carrier");
	property p_m0_burst;
		!mode && byte_done |-> edge_cnt_reg == NBITS;
	endproperty
	a_m0_burst: assert property (p_m0_burst)
		else $error("mode 0 burst was not eight pulses");
	property p_m0_centre;
		!mode && bit_sample |=> !O_DATA_CLOCK [*2];
	endproperty
	a_m0_centre: assert property (p_m0_centre)
		else $error("mode 0 clock not low across the bit centre");
	property p_data_clock_dir;
		mode |-> !O_DATA_CLOCK_OE;
	endproperty
	a_data_clock_dir: assert property (p_data_clock_dir)
		else $error("data clock driven in mode 1");
	property p_m1_rel;
		mode && !O_BYTE_READY_N && data_clock_rise && gate |=> O_BYTE_READY_N;
	endproperty
	a_m1_rel: assert property (p_m1_rel)
		else $error("byte ready not released by clock edge");
	property p_m1_tmo;
		rdy_low_reg <= HALF_CYC;
	endproperty
	a_m1_tmo: assert property (p_m1_tmo)
		else $error("byte ready low beyond half a bit");
	property p_m1_lsb;
		mode && gate && data_clock_rise && left_reg != '0 && !byte_done |=>
			O_DATA == $past(shift_reg[0]);
	endproperty
	a_m1_lsb: assert property (p_m1_lsb)
		else $error("mode 1 bit order wrong");
	property p_m1_ign;
		mode && left_reg == '0 && !byte_done ##1 mode |-> $stable(O_DATA);
	endproperty
	a_m1_ign: assert property (p_m1_ign)
		else $error("data moved after the last bit");
	property p_m1_frz;
		mode && !gate |=> O_BYTE_READY_N && left_reg == '0;
	endproperty
	a_m1_frz: assert property (p_m1_frz)
		else $error("mode 1 updated without carrier");

	c_m0_byte: cover property (!mode && byte_done ##1 !O_BYTE_READY_N);
	c_m1_read: cover property (mode && byte_done ##[1:1000] data_clock_rise ##1 O_BYTE_READY_N);
	c_ring: cover property ($fell(O_RING_DETECT_N));
	c_alert: cover property ($rose(O_ALERT_QUALIFIED));

	// alert guard timing, cleared to tone absent by sleep
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			alert_raw_reg <= 1'b0;
			alert_q_reg   <= 1'b0;
			al_cnt_reg    <= '0;
		end else begin
			alert_raw_reg <= pin_sync_reg[cidfo_pkg::IX_TONEH] & pin_sync_reg[cidfo_pkg::IX_TONEL]
				& ~sleep;
			if (sleep) begin
				alert_q_reg <= 1'b0;
				al_cnt_reg  <= '0;
			end else if (alert_raw_reg == alert_q_reg) begin
				al_cnt_reg <= '0;
			end else if ((al_cnt_reg + 24'h000001) >= al_limit) begin
				alert_q_reg <= ~alert_q_reg;
				al_cnt_reg  <= '0;
			end else begin
				al_cnt_reg <= al_cnt_reg + 24'h000001;
			end
		end
	end
	assign al_limit          = alert_q_reg ? absent_reg : present_reg;
	assign O_ALERT_RAW       = alert_raw_reg;
	assign O_ALERT_QUALIFIED = alert_q_reg;

	property p_sleep_al;
		sleep |=> !O_ALERT_QUALIFIED && al_cnt_reg == '0;
	endproperty
	a_sleep_al: assert property (p_sleep_al)
		else $error("alert not cleared in sleep");
	property p_al_rise;
		$rose(O_ALERT_QUALIFIED) |-> $past(alert_raw_reg, 2);
	endproperty
	a_al_rise: assert property (p_al_rise)
		else $error("alert qualified without raw tone");

	// ring envelope keeps running in sleep; starts active to mimic an uncharged delay
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ring_on_reg  <= 1'b1;
			ring_cnt_reg <= RING_RST;
		end else if (pin_sync_reg[cidfo_pkg::IX_RING]) begin
			ring_on_reg  <= 1'b1;
			ring_cnt_reg <= ring_delay_reg;
		end else if (ring_cnt_reg != '0) begin
			ring_cnt_reg <= ring_cnt_reg - 24'h000001;
		end else begin
			ring_on_reg <= 1'b0;
		end
	end
	assign O_RING_DETECT_N = ~ring_on_reg;

	property p_ring;
		pin_sync_reg[cidfo_pkg::IX_RING] |=> !O_RING_DETECT_N;
	endproperty
	a_ring: assert property (p_ring)
		else $error("ring detect not active while ringing");

	// open drain interrupt, the pin level itself is always low
	assign O_IRQ_N    = 1'b0;
	assign O_IRQ_N_OE = ring_on_reg | ~rdy_n_reg | alert_q_reg;

	property p_irq;
		O_IRQ_N_OE == (!O_RING_DETECT_N || !O_BYTE_READY_N || O_ALERT_QUALIFIED) && !O_IRQ_N;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt does not follow its three sources");

	// apb slave, zero wait states; read data latched in the setup cycle
	assign addr_ok = I_PADDR == cidfo_pkg::RING_DELAY_OFS || I_PADDR == cidfo_pkg::PRESENT_OFS ||
		I_PADDR == cidfo_pkg::ABSENT_OFS || I_PADDR == cidfo_pkg::STATUS_OFS;

	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ring_delay_reg <= RING_RST;
			present_reg    <= PRES_RST;
			absent_reg     <= ABS_RST;
		end else if (I_PSEL && I_PENABLE && I_PWRITE) begin
			case (I_PADDR)
				cidfo_pkg::RING_DELAY_OFS: ring_delay_reg <= I_PWDATA[23:0];
				cidfo_pkg::PRESENT_OFS:    present_reg    <= I_PWDATA[23:0];
				cidfo_pkg::ABSENT_OFS:     absent_reg     <= I_PWDATA[23:0];
				default:                   ring_delay_reg <= ring_delay_reg;
			endcase
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= '0;
		end else if (I_PSEL && !I_PENABLE) begin
			case (I_PADDR)
				cidfo_pkg::RING_DELAY_OFS: prdata_reg <= {8'h00, ring_delay_reg};
				cidfo_pkg::PRESENT_OFS:    prdata_reg <= {8'h00, present_reg};
				cidfo_pkg::ABSENT_OFS:     prdata_reg <= {8'h00, absent_reg};
				cidfo_pkg::STATUS_OFS: begin
					prdata_reg <= '0;
					prdata_reg[cidfo_pkg::ST_CD_BIT]    <= cd_on_reg;
					prdata_reg[cidfo_pkg::ST_ALERT_BIT] <= alert_q_reg;
					prdata_reg[cidfo_pkg::ST_RING_BIT]  <= ring_on_reg;
					prdata_reg[cidfo_pkg::ST_MODE_BIT]  <= mode;
					prdata_reg[cidfo_pkg::ST_BYTE_LSB +: 8] <= last_byte_reg;
				end
				default: prdata_reg <= '0;
			endcase
		end
	end
	assign O_PRDATA  = prdata_reg;
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;
endmodule : cidfo_top

// *** sim/cidfo_mcu_model.sv ***
// microcontroller model that clocks bytes out of the serial port in mode 1
`timescale 1ns/100ps
module cidfo_mcu_model (
	// control
	input  wire logic       i_enable,
	// serial port
	input  wire logic       i_byte_ready_n,
	input  wire logic       i_data,
	output logic            o_data_clock,
	// result
	output logic [7:0]      o_byte,
	output logic            o_done
);
	// clock stands low between bytes; 200 ns link period
	initial begin
		o_data_clock = 1'b0;
		o_byte = 8'h00;
		o_done = 1'b0;
		forever begin
			@(negedge i_byte_ready_n);
			if (i_enable) begin
				o_done = 1'b0;
				// offset from the system clock edges, as an unrelated clock would be
				#310;
				for (int i = 0; i < 8; i++) begin
					o_data_clock = 1'b1;
					#100;
					o_data_clock = 1'b0;
					#100;
					// sampled late: the data line lags the clock by a few system clocks
					o_byte[i] = i_data;
				end
				o_done = 1'b1;
			end
		end
	end
endmodule : cidfo_mcu_model

// *** sim/cidfo_top_test.sv ***
// self-checking bench for the caller id fsk output interface
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module cidfo_top_test;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic mode = 0, fsk_enable = 0, slp = 0, fbit = 1, amp = 0, th = 0, tl = 0, ring = 0, mcu_en = 0;
	logic data_clock_o, data_clock_oe, data_clock_m, data_clock_w, data, brdy_n, cd_n, araw, aq, ring_n;
	logic irq_o, irq_oe, irq_w, done;
	logic [7:0] mbyte, cap;
	int failures = 0, check_count = 0, rises = 0, lo_cnt = 0;
	assign data_clock_w = data_clock_oe ? data_clock_o : data_clock_m;
	assign irq_w = irq_oe ? irq_o : 1'b1;
	always #12.5 clk = ~clk;
	// a bit must outlast the fixed mode 0 clock low time of 80 cycles
	cidfo_top #(.BIT_CYC(24'h0000c8), .HALF_CYC(24'h000064), .CD_CYC(24'd100),
		.RING_RST(24'd50), .PRES_RST(24'd20)) dut (
		.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .I_MODE(mode), .I_FSK_ENABLE(fsk_enable), .I_SLEEP(slp),
		.I_FSK_BIT(fbit), .I_AMP_OK(amp), .I_TONE_HIGH(th), .I_TONE_LOW(tl),
		.I_RING_SENSE_IN(ring), .I_DATA_CLOCK(data_clock_w), .O_DATA_CLOCK(data_clock_o),
		.O_DATA_CLOCK_OE(data_clock_oe), .O_DATA(data), .O_BYTE_READY_N(brdy_n),
		.O_CARRIER_DETECT_N(cd_n), .O_ALERT_RAW(araw), .O_ALERT_QUALIFIED(aq),
		.O_RING_DETECT_N(ring_n), .O_IRQ_N(irq_o), .O_IRQ_N_OE(irq_oe));
	cidfo_mcu_model mcu (.i_enable(mcu_en), .i_byte_ready_n(brdy_n), .i_data(data),
		.o_data_clock(data_clock_m), .o_byte(mbyte), .o_done(done));
	always @(posedge data_clock_o) if (!mode) begin
		rises++;
		cap = {data, cap[7:1]};
	end
	always @(posedge clk) if (brdy_n === 1'b0) lo_cnt++;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			fbit <= f[i];
			cyc(200);
		end
	endtask : send
	task automatic print_verdict();
		if (failures == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	// generous bound: the whole sequence needs well under 20000 cycles
	initial begin
		#750000;
		failures++;
		print_verdict();
	end
	initial begin
		cyc(12);
		rst_n <= 1'b1;
		cyc(4);
		`CHK("carrier_n", 1'b1, cd_n)
		`CHK("ready_n", 1'b1, brdy_n)
		repeat (200) if (ring_n !== 1'b1) @(posedge clk);
		apb(1, 8'h00, 32'd40);
		apb(1, 8'h04, 32'd20);
		apb(1, 8'h08, 32'd20);
		apb(0, 8'h00, 0);
		`CHK("ring_delay", 32'd40, rd)
		apb(0, 8'h10, 0);
		`CHK("unmapped", 1'b1, err)
		fsk_enable <= 1;
		amp <= 1;
		cyc(450);
		`CHK("carrier_early", 1'b1, cd_n)
		cyc(80);
		`CHK("carrier_on", 1'b0, cd_n)
		rises = 0;
		lo_cnt = 0;
		send(8'ha5);
		`CHK("clocks", 8, rises)
		`CHK("m0_byte", 8'ha5, cap)
		`CHK("irq_ready", 1'b0, irq_w)
		apb(0, 8'h0c, 0);
		`CHK("status_byte", 8'ha5, rd[15:8])
		cyc(4100);
		`CHK("ready_pulse", 1'b1, (lo_cnt >= 3990 && lo_cnt <= 4010))
		mode <= 1;
		mcu_en <= 1;
		cyc(10);
		send(8'h3c);
		repeat (200) if (done !== 1'b1) @(posedge clk);
		`CHK("m1_byte", 8'h3c, mbyte)
		`CHK("ready_release", 1'b1, brdy_n)
		mcu_en <= 0;
		cyc(2);
		lo_cnt = 0;
		send(8'h81);
		cyc(40);
		`CHK("ready_timeout", 100, lo_cnt)
		mode <= 0;
		amp <= 0;
		cyc(130);
		`CHK("carrier_off", 1'b1, cd_n)
		rises = 0;
		lo_cnt = 0;
		send(8'h00);
		`CHK("idle_clocks", 0, rises)
		`CHK("idle_data", 1'b1, data)
		mode <= 1;
		cyc(10);
		send(8'h00);
		`CHK("frozen_ready", 0, lo_cnt)
		th <= 1;
		tl <= 1;
		cyc(8);
		`CHK("alert_raw", 1'b1, araw)
		`CHK("alert_early", 1'b0, aq)
		cyc(30);
		`CHK("alert_on", 1'b1, aq)
		`CHK("irq_alert", 1'b0, irq_w)
		slp <= 1;
		cyc(6);
		`CHK("alert_sleep", 1'b0, aq)
		`CHK("raw_sleep", 1'b0, araw)
		th <= 0;
		tl <= 0;
		slp <= 0;
		cyc(10);
		`CHK("irq_idle", 1'b1, irq_w)
		slp <= 1;
		ring <= 1;
		cyc(5);
		`CHK("ring_on", 1'b0, ring_n)
		`CHK("irq_ring", 1'b0, irq_w)
		ring <= 0;
		cyc(30);
		`CHK("ring_hold", 1'b0, ring_n)
		cyc(20);
		`CHK("ring_off", 1'b1, ring_n)
		print_verdict();
	end
endmodule : cidfo_top_test
